// [hw/tpd_pkg.sv]
// Package of offsets, field positions, reset values and carriers for the touch pattern detector
package tpd_pkg;
    // Number of touch inputs
    localparam int N_INPUTS = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h00;
    localparam logic [7:0] IDX_PDC = 8'h2b;
    localparam logic [7:0] IDX_MASK = 8'h2d;
    localparam logic [7:0] IDX_RCC = 8'h2f;
    localparam logic [7:0] IDX_THR0 = 8'h30;
    localparam logic [7:0] IDX_THR7 = 8'h37;
    localparam logic [7:0] IDX_SBY_THR = 8'h43;
    // Reset values
    localparam logic [7:0] RST_PDC = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_RCC = 8'h8a;
    localparam logic [6:0] RST_THR = 7'h40;
    // Pattern configuration fields
    localparam int PDC_EN_BIT = 7;
    localparam int PDC_TH_LSB = 2;
    localparam int PDC_MODE_BIT = 1;
    localparam int PDC_ALERT_BIT = 0;
    // Recalibration configuration fields
    localparam int RCC_BCAST_BIT = 7;
    localparam int RCC_KEEP_ACC_BIT = 6;
    localparam int RCC_KEEP_NEG_BIT = 5;
    localparam int RCC_NEG_LSB = 3;
    localparam int RCC_CAL_LSB = 0;
    // Status register fields
    localparam int STS_EVENT_BIT = 0;
    localparam int STS_BLOCK_BIT = 1;
    // Negative delta trigger counts
    localparam logic [5:0] NEG_CNT_8 = 6'h08;
    localparam logic [5:0] NEG_CNT_16 = 6'h10;
    localparam logic [5:0] NEG_CNT_32 = 6'h20;
    // Calibration decode bases
    localparam logic [8:0] CAL_SAMP_BASE = 9'h010;
    localparam logic [8:0] CAL_SAMP_MAX = 9'h100;
    localparam logic [12:0] CAL_PER_BASE = 13'h0010;
    localparam logic [12:0] CAL_PER_LONG = 13'h0400;
    localparam logic [2:0] CAL_LONG_CODE = 3'h5;

    // One polling cycle of sensed results
    typedef struct packed {
        logic [7:0][7:0] delta;
        logic [7:0] noise;
        logic [7:0] negative;
    } tpd_poll_t;

    // Calibration settings carried out to the sensing engine
    typedef struct packed {
        logic [8:0] samples;
        logic [12:0] period;
    } tpd_cal_t;
endpackage : tpd_pkg

// [hw/tpd_detector.sv]
// Touch pattern detector with recalibration configuration and Wishbone registers
//
// Behaviour
// - Enable bit 7 gates pattern events, default off
// - Active uses input threshold, standby uses standby
// - Fraction field: 12.5, 25, 37.5, 100 percent
// - Pattern mode: all masked inputs qualify
// - Count mode: qualifying count reaches mask popcount
// - Evaluate one polling cycle only
// - Event blocks touches and flags interrupt
// - Blocking follows condition, resumes when gone
// - Sticky status cleared by zero write after
// - Alert enable drives active-low alert pin
// - Mask bit per input, resets all ones
// - Broadcast bit copies input 1 threshold write
// - Inputs 2 to 8 always writable individually
// - Noise clears accumulation unless keep bit set
// - Noise clears negative counter unless keep set
// - Field selects negative counts before recalibration
// - Negative count codes 8, 16, 32, disabled
// - Calibration code sets samples and period
`timescale 1ns/10ps
module tpd_detector (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic poll_valid_i,
    input wire tpd_pkg::tpd_poll_t poll_i,
    input wire logic standby_i,
    output logic touches_blocked_o,
    output logic alert_n_o,
    output logic [7:0] touch_status_o,
    output logic [7:0] recal_start_o,
    output logic [7:0] accum_clear_o,
    output tpd_pkg::tpd_cal_t cal_o
);

    // Population count of an input vector
    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < 8; k++) begin
            n = n + {3'h0, v[k]};
        end
        return n;
    endfunction : count_ones

    // Fraction of a threshold picked by the two-bit select
    function automatic logic [6:0] frac_thr(input logic [6:0] t, input logic [1:0] s);
        logic [6:0] r;
        r = t;
        unique case (s)
            2'h0: r = t >> 3;
            2'h1: r = t >> 2;
            2'h2: r = (t >> 2) + (t >> 3);
            2'h3: r = t;
        endcase
        return r;
    endfunction : frac_thr

    // Negative delta counts needed, zero means disabled
    function automatic logic [5:0] neg_target(input logic [1:0] s);
        logic [5:0] r;
        r = 6'h00;
        unique case (s)
            2'h0: r = tpd_pkg::NEG_CNT_8;
            2'h1: r = tpd_pkg::NEG_CNT_16;
            2'h2: r = tpd_pkg::NEG_CNT_32;
            2'h3: r = 6'h00;
        endcase
        return r;
    endfunction : neg_target

    logic [7:0] pattern_detect_config;
    logic [7:0] pattern_input_mask;
    logic [7:0] recalibration_config;
    logic [6:0] thr [8];
    logic [6:0] standby_thr;
    logic pattern_event_status;
    logic [5:0] neg_cnt [8];
    logic [7:0] qual;
    logic [7:0] raw_touch;

    // Bus decode
    wire logic bus_req = wb_cyc_i & wb_stb_i;
    wire logic [7:0] idx = wb_adr_i[9:2];
    wire logic wr_ok = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire logic wr_status = wr_ok & (idx == tpd_pkg::IDX_STATUS);
    wire logic wr_pdc = wr_ok & (idx == tpd_pkg::IDX_PDC);
    wire logic wr_mask = wr_ok & (idx == tpd_pkg::IDX_MASK);
    wire logic wr_rcc = wr_ok & (idx == tpd_pkg::IDX_RCC);
    wire logic wr_sby = wr_ok & (idx == tpd_pkg::IDX_SBY_THR);
    wire logic in_thr = (idx >= tpd_pkg::IDX_THR0) & (idx <= tpd_pkg::IDX_THR7);
    wire logic [2:0] thr_sel = idx[2:0];

    // Configuration fields
    wire logic pattern_detect_enable = pattern_detect_config[tpd_pkg::PDC_EN_BIT];
    wire logic [1:0] pattern_threshold_select =
        pattern_detect_config[tpd_pkg::PDC_TH_LSB +: 2];
    wire logic pattern_compare_mode = pattern_detect_config[tpd_pkg::PDC_MODE_BIT];
    wire logic pattern_alert_enable = pattern_detect_config[tpd_pkg::PDC_ALERT_BIT];
    wire logic broadcast_threshold_load = recalibration_config[tpd_pkg::RCC_BCAST_BIT];
    wire logic keep_accumulation_on_noise =
        recalibration_config[tpd_pkg::RCC_KEEP_ACC_BIT];
    wire logic keep_negative_counter_on_noise =
        recalibration_config[tpd_pkg::RCC_KEEP_NEG_BIT];
    wire logic [1:0] negative_delta_trigger_count =
        recalibration_config[tpd_pkg::RCC_NEG_LSB +: 2];
    wire logic [2:0] cal_code = recalibration_config[tpd_pkg::RCC_CAL_LSB +: 3];
    wire logic [5:0] neg_goal = neg_target(negative_delta_trigger_count);

    // Read selection
    wire logic [7:0] status_rd = {6'h00, touches_blocked_o, pattern_event_status};
    wire logic [7:0] rd_mux =
        (idx == tpd_pkg::IDX_STATUS) ? status_rd :
        (idx == tpd_pkg::IDX_PDC) ? pattern_detect_config :
        (idx == tpd_pkg::IDX_MASK) ? pattern_input_mask :
        (idx == tpd_pkg::IDX_RCC) ? recalibration_config :
        (idx == tpd_pkg::IDX_SBY_THR) ? {1'b0, standby_thr} :
        in_thr ? {1'b0, thr[thr_sel]} : 8'h00;

    // Bus answer: one wait state, ack drops after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req & ~wb_ack_o) begin
                wb_dat_o <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pattern_detect_config <= tpd_pkg::RST_PDC;
            pattern_input_mask <= tpd_pkg::RST_MASK;
            recalibration_config <= tpd_pkg::RST_RCC;
            standby_thr <= tpd_pkg::RST_THR;
        end else if (ce_i) begin
            if (wr_pdc) begin
                pattern_detect_config <= wb_dat_i[7:0] & 8'h8f;
            end
            if (wr_mask) begin
                pattern_input_mask <= wb_dat_i[7:0];
            end
            if (wr_rcc) begin
                recalibration_config <= wb_dat_i[7:0];
            end
            if (wr_sby) begin
                standby_thr <= wb_dat_i[6:0];
            end
        end
    end

    // Per-input thresholds, qualification and negative counters
    for (genvar i = 0; i < 8; i++) begin : g_in
        wire logic own_wr = wr_ok & (idx == tpd_pkg::IDX_THR0 + 8'(i));
        wire logic bc_wr = wr_ok & (idx == tpd_pkg::IDX_THR0) & broadcast_threshold_load;
        wire logic [6:0] base_thr = standby_i ? standby_thr : thr[i];
        wire logic [6:0] pat_thr = frac_thr(base_thr, pattern_threshold_select);
        wire logic noisy = poll_i.noise[i];
        wire logic neg = poll_i.negative[i];
        wire logic [5:0] cnt_inc = neg_cnt[i] + 6'h01;
        wire logic hit = neg & ~noisy &
            (neg_goal != 6'h00) & (cnt_inc == neg_goal);

        assign qual[i] = (poll_i.delta[i] > {1'b0, pat_thr}) | noisy;
        assign raw_touch[i] = poll_i.delta[i] > {1'b0, base_thr};

        // Threshold register, with broadcast from input 1
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                thr[i] <= tpd_pkg::RST_THR;
            end else if (ce_i && (own_wr || bc_wr)) begin
                thr[i] <= wb_dat_i[6:0];
            end
        end

        // Consecutive negative delta counter
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                neg_cnt[i] <= 6'h00;
                recal_start_o[i] <= 1'b0;
                accum_clear_o[i] <= 1'b0;
            end else if (ce_i) begin
                recal_start_o[i] <= poll_valid_i & hit;
                accum_clear_o[i] <= poll_valid_i & noisy &
                    ~keep_accumulation_on_noise;
                if (poll_valid_i) begin
                    if (noisy && !keep_negative_counter_on_noise) begin
                        neg_cnt[i] <= 6'h00;
                    end else if (noisy) begin
                        neg_cnt[i] <= neg_cnt[i];
                    end else if (!neg || hit) begin
                        neg_cnt[i] <= 6'h00;
                    end else if (neg_goal != 6'h00) begin
                        neg_cnt[i] <= cnt_inc;
                    end
                end
            end
        end
    end

    // Pattern condition from the current polling cycle only
    wire logic pattern_hit = (qual & pattern_input_mask) == pattern_input_mask;
    wire logic count_hit = count_ones(qual) >= count_ones(pattern_input_mask);
    wire logic cond = pattern_detect_enable &
        (pattern_compare_mode ? pattern_hit : count_hit);
    wire logic ev_set = poll_valid_i & cond;
    wire logic ev_clr = wr_status & ~wb_dat_i[tpd_pkg::STS_EVENT_BIT] &
        ~touches_blocked_o;
    wire logic next_status = ev_set | (pattern_event_status & ~ev_clr);

    // Event status, blocking and alert
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pattern_event_status <= 1'b0;
            touches_blocked_o <= 1'b0;
            alert_n_o <= 1'b1;
            touch_status_o <= 8'h00;
        end else if (ce_i) begin
            pattern_event_status <= next_status;
            alert_n_o <= ~(next_status & pattern_alert_enable);
            if (poll_valid_i) begin
                touches_blocked_o <= cond;
                touch_status_o <= raw_touch & {8{~cond}};
            end
        end
    end

    // Calibration samples and update period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_o <= '0;
        end else if (ce_i) begin
            if (cal_code < tpd_pkg::CAL_LONG_CODE) begin
                cal_o.samples <= tpd_pkg::CAL_SAMP_BASE << cal_code;
                cal_o.period <= tpd_pkg::CAL_PER_BASE << cal_code;
            end else begin
                cal_o.samples <= tpd_pkg::CAL_SAMP_MAX;
                cal_o.period <= tpd_pkg::CAL_PER_LONG << (cal_code - tpd_pkg::CAL_LONG_CODE);
            end
        end
    end

    // Checks
    event_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && !pattern_detect_enable && !pattern_event_status
        && !wr_pdc |=> !pattern_event_status && !touches_blocked_o)
        else $error("pattern event while detection disabled");
    pattern_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && pattern_detect_enable && pattern_compare_mode
        && ((qual & pattern_input_mask) == pattern_input_mask) |=> pattern_event_status)
        else $error("pattern match not flagged");
    count_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && pattern_detect_enable && !pattern_compare_mode
        && (count_ones(qual) < count_ones(pattern_input_mask))
        && !pattern_event_status |=> !pattern_event_status)
        else $error("count mode flagged too few inputs");
    block_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i |=> touches_blocked_o == $past(cond))
        else $error("blocking does not follow condition");
    touch_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && cond |=> touch_status_o == 8'h00)
        else $error("touch status set while blocked");
    sticky_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && pattern_event_status && (!wr_status || touches_blocked_o)
        |=> pattern_event_status)
        else $error("status lost without proper clear");
    alert_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ev_set && pattern_alert_enable |=> !alert_n_o ##1 1'b1)
        else $error("alert not asserted on event");
    bcast_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_ok && idx == tpd_pkg::IDX_THR0 && broadcast_threshold_load
        |=> thr[7] == $past(wb_dat_i[6:0]) && thr[3] == $past(wb_dat_i[6:0]))
        else $error("broadcast threshold not copied");
    neg_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && negative_delta_trigger_count == 2'h3 && !wr_rcc
        |=> recal_start_o == 8'h00)
        else $error("recalibration started while disabled");
    accum_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && poll_i.noise[0] && !keep_accumulation_on_noise
        |=> accum_clear_o[0])
        else $error("accumulation not cleared on noise");

    // Counter, calibration, bus and enable checks
    neg_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && poll_i.noise[0] && keep_negative_counter_on_noise
        |=> neg_cnt[0] == $past(neg_cnt[0]) && !recal_start_o[0])
        else $error("negative counter moved on noise");
    neg_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && poll_i.noise[0] && !keep_negative_counter_on_noise
        |=> neg_cnt[0] == 6'h00)
        else $error("negative counter kept on noise");
    recal_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && poll_i.negative[0] && !poll_i.noise[0]
        && neg_goal != 6'h00 && neg_cnt[0] == neg_goal - 6'h01
        |=> recal_start_o[0] && neg_cnt[0] == 6'h00)
        else $error("recalibration not started at count");
    count_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && poll_valid_i && pattern_detect_enable && !pattern_compare_mode
        && (count_ones(qual) >= count_ones(pattern_input_mask))
        |=> pattern_event_status && touches_blocked_o)
        else $error("count mode missed an event");
    status_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_status && !wb_dat_i[tpd_pkg::STS_EVENT_BIT] && !touches_blocked_o
        && !(poll_valid_i && cond) |=> !pattern_event_status)
        else $error("status not cleared by zero write");
    alert_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !pattern_alert_enable |=> alert_n_o)
        else $error("alert asserted while disabled");
    thr_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_ok && idx == tpd_pkg::IDX_THR7 |=> thr[7] == $past(wb_dat_i[6:0]))
        else $error("individual threshold write lost");
    cal_long_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && cal_code == 3'h7 |=> cal_o.samples == 9'h100 && cal_o.period == 13'h1000)
        else $error("longest calibration period wrong");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
    frozen_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(pattern_event_status) && $stable(touches_blocked_o))
        else $error("state moved while clock enable low");

endmodule : tpd_detector

// [verification/tpd_detector_tb_top.sv]
// Self-checking testbench of the touch pattern detector
`timescale 1ns/10ps
module tpd_detector_tb_top;
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, poll_valid_i, standby_i;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i, sel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic wb_ack_o, touches_blocked_o, alert_n_o;
    logic [7:0] touch_status_o, recal_start_o, accum_clear_o, pdc, mask, rcc;
    tpd_pkg::tpd_poll_t poll_i, p;
    tpd_pkg::tpd_cal_t cal_o;
    int error_cnt = 0;
    int n_compared = 0;
    int seed = 32'h3f40;
    int thr[8];
    int sby, sts, blk, ncnt, i, v;

    tpd_detector uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .poll_valid_i(poll_valid_i), .poll_i(poll_i), .standby_i(standby_i),
        .touches_blocked_o(touches_blocked_o), .alert_n_o(alert_n_o),
        .touch_status_o(touch_status_o), .recal_start_o(recal_start_o),
        .accum_clear_o(accum_clear_o), .cal_o(cal_o));

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_sim;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Classic single Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rchk(input logic [7:0] idx, input int exp);
        wb(1'b0, idx, 8'h00);
        chk("register", exp, rd);
    endtask : rchk

    function automatic int frac(input int t, input logic [1:0] s);
        case (s)
            2'h0: return t >> 3;
            2'h1: return t >> 2;
            2'h2: return (t >> 2) + (t >> 3);
            default: return t;
        endcase
    endfunction : frac

    function automatic logic [21:0] calx(input logic [2:0] c);
        if (c < 3'h5) return {9'h010 << c, 13'h0010 << c};
        return {9'h100, 13'h0400 << (c - 3'h5)};
    endfunction : calx

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        pdc = 8'h00;
        mask = 8'hff;
        rcc = 8'h8a;
        sby = 8'h40;
        sts = 0;
        blk = 0;
        ncnt = 0;
        foreach (thr[k]) thr[k] = 8'h40;
    endtask : do_reset

    // One polling cycle against the behavioural model
    task automatic poll(input tpd_pkg::tpd_poll_t pv);
        int ev, nd;
        logic [7:0] qv, tv, rx;
        qv = 8'h00;
        tv = 8'h00;
        rx = 8'h00;
        for (int k = 0; k < 8; k++) begin
            qv[k] = (pv.delta[k] > frac(standby_i ? sby : thr[k], pdc[3:2])) || pv.noise[k];
            tv[k] = pv.delta[k] > thr[k];
        end
        if (pdc[1]) ev = ((qv & mask) == mask);
        else ev = $countones(qv) >= $countones(mask);
        blk = pdc[7] && ev;
        if (blk) sts = 1;
        nd = (rcc[4:3] == 2'h3) ? 0 : 8 << rcc[4:3];
        if (pv.noise == 8'hff) begin
            if (!rcc[5]) ncnt = 0;
        end else if (pv.negative != 8'hff) begin
            ncnt = 0;
        end else if (nd != 0) begin
            ncnt++;
            if (ncnt == nd) rx = 8'hff;
            if (ncnt == nd) ncnt = 0;
        end
        @(posedge clk_i);
        poll_valid_i <= 1'b1;
        poll_i <= pv;
        @(posedge clk_i);
        poll_valid_i <= 1'b0;
        #1;
        chk("blocked", blk, touches_blocked_o);
        chk("alert_n", !(sts && pdc[0]), alert_n_o);
        if (blk || !standby_i) chk("touch", blk ? 8'h00 : tv, touch_status_o);
        chk("accum", pv.noise & {8{~rcc[6]}}, accum_clear_o);
        chk("recal", rx, recal_start_o);
    endtask : poll

    // Bounded run guard
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end

    // Main sequence
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, poll_valid_i, standby_i} = 5'h00;
        ce_i = 1'b1;
        wb_sel_i = 4'h0;
        sel = 4'h1;
        wb_adr_i = 10'h000;
        wb_dat_i = 32'h0;
        poll_i = '0;
        rst_i = 1'b1;
        do_reset();
        rchk(tpd_pkg::IDX_PDC, 8'h00);
        rchk(tpd_pkg::IDX_MASK, 8'hff);
        rchk(tpd_pkg::IDX_RCC, 8'h8a);
        wb(1'b1, 8'h10, 8'h5a);
        rchk(8'h10, 0);
        chk("cal", calx(3'h2), cal_o);
        for (int r = 0; r < 14; r++) begin
            rcc = $random(seed);
            rcc[5] = rcc[6];
            wb(1'b1, tpd_pkg::IDX_RCC, rcc);
            for (int w = 0; w < 3; w++) begin
                i = (w == 0) ? 0 : $random(seed) & 7;
                v = $random(seed) & 8'h7f;
                wb(1'b1, tpd_pkg::IDX_THR0 + i[7:0], v[7:0]);
                if (i == 0 && rcc[7]) foreach (thr[k]) thr[k] = v;
                else thr[i] = v;
            end
            pdc = $random(seed) & 8'h8f;
            wb(1'b1, tpd_pkg::IDX_PDC, $random(seed) & 8'h70 | pdc);
            mask = $random(seed) & $random(seed);
            wb(1'b1, tpd_pkg::IDX_MASK, mask);
            sby = $random(seed) & 8'h7f;
            wb(1'b1, tpd_pkg::IDX_SBY_THR, sby[7:0]);
            standby_i <= $random(seed) & 1;
            chk("cal", calx(rcc[2:0]), cal_o);
            rchk(tpd_pkg::IDX_RCC, rcc);
            rchk(tpd_pkg::IDX_PDC, pdc);
            rchk(tpd_pkg::IDX_MASK, mask);
            for (int k = 0; k < 8; k++) rchk(tpd_pkg::IDX_THR0 + k[7:0], thr[k]);
            for (int n = 0; n < 20; n++) begin
                p = '0;
                for (int k = 0; k < 8; k++) p.delta[k] = $random(seed) & 8'h3f;
                p.noise = $random(seed) & $random(seed) & $random(seed);
                poll(p);
                rchk(tpd_pkg::IDX_STATUS, {blk[0], sts[0]});
                if ($random(seed) & 1) begin
                    wb(1'b1, tpd_pkg::IDX_STATUS, 8'h00);
                    if (!blk) sts = 0;
                end
            end
        end
        // Byte lane 0 off: the write is ignored
        sel = 4'h0;
        wb(1'b1, tpd_pkg::IDX_MASK, 8'h00);
        sel = 4'h1;
        rchk(tpd_pkg::IDX_MASK, mask);
        // Clock enable low freezes a poll that would block
        pdc = 8'h00;
        wb(1'b1, tpd_pkg::IDX_PDC, pdc);
        poll(p);
        mask = 8'h00;
        wb(1'b1, tpd_pkg::IDX_MASK, mask);
        pdc = 8'h80;
        wb(1'b1, tpd_pkg::IDX_PDC, pdc);
        @(posedge clk_i);
        ce_i <= 1'b0;
        poll_valid_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        ce_i <= 1'b1;
        poll_valid_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("frozen", 0, touches_blocked_o);
        poll(p);
        // Negative-delta trigger counts for every code
        for (int c = 0; c < 4; c++) begin
            do_reset();
            standby_i <= 1'b0;
            rcc = 8'h82 | (c << 3) | ((c & 1) ? 8'h60 : 8'h00);
            wb(1'b1, tpd_pkg::IDX_RCC, rcc);
            p = '0;
            p.negative = 8'hff;
            for (int n = 0; n < 36; n++) begin
                p.noise = (n == 2) ? 8'hff : 8'h00;
                poll(p);
            end
        end
        end_sim();
    end
endmodule : tpd_detector_tb_top
